/* File: analog_pi_pkg.sv */
// Constants, types and decode helpers for the analog process image block.
// Assumes one 50 MHz clock and a byte-wide process image port on each side.

package analog_pi_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned CH_NUM = 10;
   localparam int unsigned CH_W = 4;
   localparam int unsigned IMG_AW = 6;
   localparam int unsigned REG_AW = 6;
   localparam int unsigned REG_NUM = 64;
   localparam int unsigned REG_IDX_W = CH_W + REG_AW;
   localparam int unsigned REG_DEPTH = CH_NUM * REG_NUM;
   localparam int unsigned ADC_W = 12;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned DIG_W = 16;

   // ==========================================================
   // Word format
   localparam int unsigned SIGN_BIT = 15;
   localparam int unsigned ADC_BIP_LSB = 4;
   localparam int unsigned ADC_UNI_LSB = 3;

   // ==========================================================
   // Channel set (terminal order)
   localparam logic [CH_NUM-1:0] CH_IS_OUTPUT = 10'h0F0;
   localparam logic [CH_NUM-1:0] CH_BIPOLAR = 10'h0CF;

   // ==========================================================
   // Slot layout
   localparam logic [1:0] OFF_CTRL = 2'h0;
   localparam logic [1:0] OFF_PAD = 2'h1;
   localparam logic [1:0] OFF_LO = 2'h2;
   localparam logic [1:0] OFF_HI = 2'h3;
   localparam logic [IMG_AW:0] SLOT_EXT = 7'h04;
   localparam logic [IMG_AW:0] SLOT_STD = 7'h02;
   localparam logic [IMG_AW:0] DIG_BYTES = 7'h02;
   localparam logic [BYTE_W-1:0] STATUS_IDLE = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   // ==========================================================
   // Types
   typedef struct packed {
      logic mode;
      logic write;
      logic [REG_AW-1:0] addr;
   } ctrl_byte_t;

   typedef struct packed {
      logic hit;
      logic dig;
      logic [CH_W-1:0] ch;
      logic [1:0] off;
   } img_sel_t;

   typedef logic [3:0][BYTE_W-1:0] chan_bytes_t;

   typedef enum logic [0:0] {
      SEQ_SCAN = 1'b0,
      SEQ_RD_WAIT = 1'b1
   } seq_state_t;

   // ==========================================================
   // Helpers
   // Maps an image byte address onto a channel slot or the digital area.
   function automatic img_sel_t img_decode(
      input logic [IMG_AW-1:0] addr,
      input logic [CH_NUM-1:0] present,
      input logic [CH_NUM-1:0] ext);
      logic [IMG_AW:0] base;
      logic [IMG_AW:0] size;
      logic [IMG_AW:0] a;
      img_sel_t sel;
      sel = '0;
      base = '0;
      size = '0;
      a = {1'b0, addr};
      for (int c = 0; c < CH_NUM; c++) begin
         size = present[c] ? (ext[c] ? SLOT_EXT : SLOT_STD) : '0;
         if (!sel.hit && (a >= base) && (a < base + size)) begin
            sel.hit = 1'b1;
            sel.ch = CH_W'(c);
            sel.off = ext[c] ? 2'(a - base) : 2'(a - base) + OFF_LO;
         end
         base = base + size;
      end
      if (!sel.hit && (a >= base) && (a < base + DIG_BYTES)) begin
         sel.hit = 1'b1;
         sel.dig = 1'b1;
         sel.off = 2'(a - base);
      end
      return sel;
   endfunction

   // Flat index of one register of one channel's register set.
   function automatic logic [REG_IDX_W-1:0] reg_index(
      input logic [CH_W-1:0] ch,
      input logic [REG_AW-1:0] addr);
      return {ch, addr};
   endfunction

endpackage

/* File: analog_pi_props.sv */
// Concurrent checks on the process image access block.
// Assumes it is bound to analog_process_image_access on one clock.
`timescale 1ns/10ps
module analog_pi_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Configuration
   input wire logic [analog_pi_pkg::CH_NUM-1:0] cfg_extended,
   input wire logic cfg_complete,
   // Image ports
   input wire logic out_wr,
   input wire logic [analog_pi_pkg::IMG_AW-1:0] out_addr,
   input wire logic [analog_pi_pkg::BYTE_W-1:0] out_wdata,
   input wire logic [analog_pi_pkg::BYTE_W-1:0] out_rdata,
   input wire logic [analog_pi_pkg::IMG_AW-1:0] in_addr,
   input wire logic [analog_pi_pkg::BYTE_W-1:0] in_rdata,
   // Terminal side
   input wire logic [analog_pi_pkg::DIG_W-1:0] dig_in,
   input wire logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::ADC_W-1:0] dac_code,
   input wire logic nv_wr,
   input wire logic [analog_pi_pkg::REG_IDX_W-1:0] nv_idx
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // Sequences
   sequence s_ctrl_wr;
      out_wr && cfg_complete && out_addr < 6'h28 && out_addr[1:0] != 2'h1;
   endsequence
   sequence s_same_rd;
      !out_wr && cfg_complete && out_addr == $past(out_addr);
   endsequence
   sequence s_dig_steady;
      $stable({dig_in, cfg_complete}) [*3] ##0 cfg_complete && in_addr == 6'h28;
   endsequence
   // ==========================================================
   // Properties
   property p_in_pad;
      cfg_complete && in_addr < 6'h28 && in_addr[1:0] == 2'h1 |=> in_rdata == 8'h00;
   endproperty
   property p_out_pad;
      cfg_complete && out_addr < 6'h28 && out_addr[1:0] == 2'h1 |=> out_rdata == 8'h00;
   endproperty
   property p_in_unmapped;
      cfg_complete && in_addr > 6'h29 |=> in_rdata == 8'h00;
   endproperty
   property p_out_unmapped;
      cfg_complete && out_addr >= 6'h28 |=> out_rdata == 8'h00;
   endproperty
   property p_dig_lo;
      s_dig_steady |=> in_rdata == $past(dig_in[7:0]);
   endproperty
   property p_readback;
      s_ctrl_wr ##1 s_same_rd |=> out_rdata == $past(out_wdata, 2);
   endproperty
   property p_dac_inputs;
      dac_code[3:0] == '0 && dac_code[9:8] == '0;
   endproperty
   property p_nv_ext;
      nv_wr |-> $past(cfg_complete) || ($past(cfg_extended) != '0);
   endproperty
   property p_nv_range;
      nv_wr |-> nv_idx[9:6] < 4'hA;
   endproperty
   a_in_pad: assert property (p_in_pad)
      else $error("input pad byte not zero");
   a_out_pad: assert property (p_out_pad)
      else $error("output pad byte not zero");
   a_in_unmapped: assert property (p_in_unmapped)
      else $error("unmapped input byte not zero");
   a_out_unmapped: assert property (p_out_unmapped)
      else $error("output digital area byte not zero");
   a_dig_lo: assert property (p_dig_lo)
      else $error("digital byte wrong");
   a_readback: assert property (p_readback)
      else $error("output byte readback wrong");
   a_dac_inputs: assert property (p_dac_inputs)
      else $error("input channel drives converter");
   a_nv_ext: assert property (p_nv_ext)
      else $error("register write without extended form");
   a_nv_range: assert property (p_nv_range)
      else $error("register write to absent channel");
endmodule
bind analog_process_image_access analog_pi_checker u_chk (
   .clk(clk), .rst_b(rst_b), .cfg_extended(cfg_extended),
   .cfg_complete(cfg_complete), .out_wr(out_wr), .out_addr(out_addr),
   .out_wdata(out_wdata), .out_rdata(out_rdata), .in_addr(in_addr),
   .in_rdata(in_rdata), .dig_in(dig_in), .dac_code(dac_code),
   .nv_wr(nv_wr), .nv_idx(nv_idx));

/* File: analog_process_image_access.sv */
// Process image access for analog and digital terminal channels.
// Assumes the PLC side uses byte ports synchronous to clk and that an
// external retained store takes the register write notices.

`timescale 1ns/10ps

module analog_process_image_access (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Configuration
   input wire logic [analog_pi_pkg::CH_NUM-1:0] cfg_extended,
   input wire logic cfg_complete,
   // Output image write port
   input wire logic out_wr,
   input wire logic [analog_pi_pkg::IMG_AW-1:0] out_addr,
   input wire logic [analog_pi_pkg::BYTE_W-1:0] out_wdata,
   output logic [analog_pi_pkg::BYTE_W-1:0] out_rdata,
   // Input image read port
   input wire logic [analog_pi_pkg::IMG_AW-1:0] in_addr,
   output logic [analog_pi_pkg::BYTE_W-1:0] in_rdata,
   // Terminal side
   input wire logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::ADC_W-1:0] adc_code,
   input wire logic [analog_pi_pkg::DIG_W-1:0] dig_in,
   output logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::ADC_W-1:0] dac_code,
   // Retained store notices
   output logic nv_wr,
   output logic [analog_pi_pkg::REG_IDX_W-1:0] nv_idx,
   output logic [analog_pi_pkg::WORD_W-1:0] nv_data
);

   // ==========================================================
   // State
   analog_pi_pkg::chan_bytes_t [analog_pi_pkg::CH_NUM-1:0] out_img_ff;
   logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::BYTE_W-1:0] status_ff;
   logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::WORD_W-1:0] regval_ff;
   logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::ADC_W-1:0] dac_ff;
   logic [analog_pi_pkg::CH_W-1:0] scan_ch_ff;
   analog_pi_pkg::seq_state_t state_ff;
   analog_pi_pkg::ctrl_byte_t cmd_ff;
   logic [analog_pi_pkg::BYTE_W-1:0] in_rdata_ff;
   logic [analog_pi_pkg::BYTE_W-1:0] out_rdata_ff;
   logic nv_wr_ff;
   logic [analog_pi_pkg::REG_IDX_W-1:0] nv_idx_ff;
   logic [analog_pi_pkg::WORD_W-1:0] nv_data_ff;

   // ==========================================================
   // Layout selection
   logic [analog_pi_pkg::CH_NUM-1:0] ext_eff;
   logic [analog_pi_pkg::CH_NUM-1:0] in_present;
   logic [analog_pi_pkg::CH_NUM-1:0] out_present;

   assign ext_eff = cfg_extended | {analog_pi_pkg::CH_NUM{cfg_complete}};
   assign in_present = ~analog_pi_pkg::CH_IS_OUTPUT |
                       {analog_pi_pkg::CH_NUM{cfg_complete}};
   assign out_present = analog_pi_pkg::CH_IS_OUTPUT |
                        {analog_pi_pkg::CH_NUM{cfg_complete}};

   analog_pi_pkg::img_sel_t rsel;
   analog_pi_pkg::img_sel_t wsel;
   assign rsel = analog_pi_pkg::img_decode(in_addr, in_present, ext_eff);
   assign wsel = analog_pi_pkg::img_decode(out_addr, out_present, ext_eff);

   // ==========================================================
   // Per channel words
   logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::WORD_W-1:0] adc_word_w;
   logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::WORD_W-1:0] out_word_w;
   logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::ADC_W-1:0] dac_code_w;
   logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::WORD_W-1:0] img_word_w;
   logic [analog_pi_pkg::CH_NUM-1:0] ctl_mode_w;

   for (genvar c = 0; c < analog_pi_pkg::CH_NUM; c++) begin : g_ch
      assign out_word_w[c] = {out_img_ff[c][analog_pi_pkg::OFF_HI],
                              out_img_ff[c][analog_pi_pkg::OFF_LO]};
      assign ctl_mode_w[c] = ext_eff[c] &&
                             out_img_ff[c][analog_pi_pkg::OFF_CTRL][7];
      assign img_word_w[c] = status_ff[c][7] ? regval_ff[c] :
                             analog_pi_pkg::CH_IS_OUTPUT[c] ? out_word_w[c] :
                             adc_word_w[c];

      analog_word_format u_fmt (
         .bipolar(analog_pi_pkg::CH_BIPOLAR[c]),
         .adc_code(adc_code[c]),
         .dac_code(dac_code_w[c]),
         .out_word(out_word_w[c]),
         .in_word(adc_word_w[c])
      );
   end

   // ==========================================================
   // Input image read
   logic [analog_pi_pkg::WORD_W-1:0] rd_word;
   logic [analog_pi_pkg::BYTE_W-1:0] rd_dig_byte;
   logic [analog_pi_pkg::BYTE_W-1:0] rd_slot_byte;
   logic [analog_pi_pkg::BYTE_W-1:0] nxt_in_rdata;

   assign rd_word = img_word_w[rsel.ch];
   assign rd_dig_byte = rsel.off[0] ?
                        dig_in[analog_pi_pkg::BYTE_W +: analog_pi_pkg::BYTE_W] :
                        dig_in[0 +: analog_pi_pkg::BYTE_W];
   assign rd_slot_byte =
      (rsel.off == analog_pi_pkg::OFF_CTRL) ? status_ff[rsel.ch] :
      (rsel.off == analog_pi_pkg::OFF_LO) ?
         rd_word[0 +: analog_pi_pkg::BYTE_W] :
      (rsel.off == analog_pi_pkg::OFF_HI) ?
         rd_word[analog_pi_pkg::BYTE_W +: analog_pi_pkg::BYTE_W] :
      analog_pi_pkg::BYTE_ZERO;
   assign nxt_in_rdata = !rsel.hit ? analog_pi_pkg::BYTE_ZERO :
                         rsel.dig ? rd_dig_byte : rd_slot_byte;

   // ==========================================================
   // Output image write and readback
   logic img_wr_en;
   logic [analog_pi_pkg::BYTE_W-1:0] nxt_out_rdata;

   assign img_wr_en = out_wr && wsel.hit && !wsel.dig &&
                      (wsel.off != analog_pi_pkg::OFF_PAD);
   assign nxt_out_rdata = (wsel.hit && !wsel.dig) ?
                          out_img_ff[wsel.ch][wsel.off] :
                          analog_pi_pkg::BYTE_ZERO;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_img_ff <= '0;
      end else if (img_wr_en) begin
         out_img_ff[wsel.ch][wsel.off] <= out_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_rdata_ff <= '0;
         out_rdata_ff <= '0;
      end else begin
         in_rdata_ff <= nxt_in_rdata;
         out_rdata_ff <= nxt_out_rdata;
      end
   end

   // ==========================================================
   // Command sequencer
   analog_pi_pkg::ctrl_byte_t cur_ctrl;
   logic [analog_pi_pkg::WORD_W-1:0] cur_word;
   logic pending;
   logic seq_write;
   logic seq_read;
   logic advance;
   logic [analog_pi_pkg::REG_IDX_W-1:0] cur_idx;
   logic [analog_pi_pkg::WORD_W-1:0] rf_rd_data;
   logic [analog_pi_pkg::CH_W-1:0] nxt_scan_ch;
   analog_pi_pkg::seq_state_t nxt_state;

   localparam logic [analog_pi_pkg::CH_W-1:0] CH_LAST =
      analog_pi_pkg::CH_W'(analog_pi_pkg::CH_NUM - 1);
   localparam logic [analog_pi_pkg::CH_W-1:0] CH_ONE = 4'h1;

   function automatic logic [analog_pi_pkg::BYTE_W-1:0] BYTE_CAST(
      input analog_pi_pkg::ctrl_byte_t b);
      return b;
   endfunction

   assign cur_ctrl = analog_pi_pkg::ctrl_byte_t'(
                     out_img_ff[scan_ch_ff][analog_pi_pkg::OFF_CTRL]);
   assign cur_word = out_word_w[scan_ch_ff];
   assign pending = ctl_mode_w[scan_ch_ff] &&
                    (status_ff[scan_ch_ff] != BYTE_CAST(cur_ctrl));
   assign seq_write = (state_ff == analog_pi_pkg::SEQ_SCAN) && pending &&
                      cur_ctrl.write;
   assign seq_read = (state_ff == analog_pi_pkg::SEQ_SCAN) && pending &&
                     !cur_ctrl.write;
   assign advance = (state_ff == analog_pi_pkg::SEQ_RD_WAIT) || !seq_read;
   assign cur_idx = analog_pi_pkg::reg_index(scan_ch_ff, cur_ctrl.addr);
   assign nxt_scan_ch = (scan_ch_ff == CH_LAST) ? '0 : scan_ch_ff + CH_ONE;
   assign nxt_state = seq_read ? analog_pi_pkg::SEQ_RD_WAIT :
                      analog_pi_pkg::SEQ_SCAN;

   terminal_register_file u_regs (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(seq_write),
      .wr_idx(cur_idx),
      .wr_data(cur_word),
      .rd_idx(cur_idx),
      .rd_data(rf_rd_data)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= analog_pi_pkg::SEQ_SCAN;
         scan_ch_ff <= '0;
         cmd_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (seq_read) begin
            cmd_ff <= cur_ctrl;
         end
         if (advance) begin
            scan_ch_ff <= nxt_scan_ch;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_ff <= '0;
         regval_ff <= '0;
      end else if (state_ff == analog_pi_pkg::SEQ_RD_WAIT) begin
         status_ff[scan_ch_ff] <= BYTE_CAST(cmd_ff);
         regval_ff[scan_ch_ff] <= rf_rd_data;
      end else if (seq_write) begin
         status_ff[scan_ch_ff] <= BYTE_CAST(cur_ctrl);
      end else if (!ctl_mode_w[scan_ch_ff]) begin
         status_ff[scan_ch_ff] <= analog_pi_pkg::STATUS_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nv_wr_ff <= 1'b0;
         nv_idx_ff <= '0;
         nv_data_ff <= '0;
      end else begin
         nv_wr_ff <= seq_write;
         if (seq_write) begin
            nv_idx_ff <= cur_idx;
            nv_data_ff <= cur_word;
         end
      end
   end

   // ==========================================================
   // Converter outputs
   // Control mode freezes the converter at its last normal value.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_ff <= '0;
      end else begin
         for (int c = 0; c < analog_pi_pkg::CH_NUM; c++) begin
            if (analog_pi_pkg::CH_IS_OUTPUT[c] && !ctl_mode_w[c]) begin
               dac_ff[c] <= dac_code_w[c];
            end
         end
      end
   end

   // ==========================================================
   // Outputs
   assign in_rdata = in_rdata_ff;
   assign out_rdata = out_rdata_ff;
   assign dac_code = dac_ff;
   assign nv_wr = nv_wr_ff;
   assign nv_idx = nv_idx_ff;
   assign nv_data = nv_data_ff;

endmodule

/* File: analog_word_format.sv */
// Converts between converter codes and the 16-bit process image word.
// Assumes 12-bit converter codes; purely combinational.

`timescale 1ns/10ps

module analog_word_format (
   // Channel kind
   input wire logic bipolar,
   // Converter side
   input wire logic [analog_pi_pkg::ADC_W-1:0] adc_code,
   output logic [analog_pi_pkg::ADC_W-1:0] dac_code,
   // Image side
   input wire logic [analog_pi_pkg::WORD_W-1:0] out_word,
   output logic [analog_pi_pkg::WORD_W-1:0] in_word
);

   // ==========================================================
   // Input direction
   // Bipolar left justify.
   logic [analog_pi_pkg::WORD_W-1:0] bip_word;
   assign bip_word = {adc_code, {analog_pi_pkg::ADC_BIP_LSB{1'b0}}};

   logic [analog_pi_pkg::WORD_W-1:0] uni_word;
   assign uni_word = {1'b0, adc_code, {analog_pi_pkg::ADC_UNI_LSB{1'b0}}};

   assign in_word = bipolar ? bip_word : uni_word;

   // ==========================================================
   // Output direction
   // Negative words clamp to zero on a unipolar channel.
   logic [analog_pi_pkg::ADC_W-1:0] bip_code;
   logic [analog_pi_pkg::ADC_W-1:0] uni_code;
   assign bip_code = out_word[analog_pi_pkg::ADC_BIP_LSB +: analog_pi_pkg::ADC_W];
   assign uni_code = out_word[analog_pi_pkg::SIGN_BIT] ? '0 :
                     out_word[analog_pi_pkg::ADC_UNI_LSB +: analog_pi_pkg::ADC_W];
   assign dac_code = bipolar ? bip_code : uni_code;

endmodule

/* File: tb.sv */
// Self-checking bench for the process image access block.
// Assumes the terminal model and the bound checker are compiled.
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [9:0] cfg_extended = 10'h000;
   logic cfg_complete = 1'b1;
   logic out_wr = 1'b0;
   logic [5:0] out_addr = 6'h00;
   logic [7:0] out_wdata = 8'h00;
   logic [5:0] in_addr = 6'h00;
   logic [7:0] out_rdata;
   logic [7:0] in_rdata;
   logic [9:0][11:0] adc_code;
   logic [9:0][11:0] dac_code;
   logic [15:0] dig_in;
   logic [15:0] nv_data;
   logic nv_wr;
   logic [9:0] nv_idx;
   logic [7:0] b;
   logic [7:0] h;
   int n_fail = 0;
   int n_compared = 0;
   always #10 clk = ~clk;
   analog_process_image_access uut (.clk(clk), .rst_b(rst_b),
      .cfg_extended(cfg_extended), .cfg_complete(cfg_complete),
      .out_wr(out_wr), .out_addr(out_addr), .out_wdata(out_wdata),
      .out_rdata(out_rdata), .in_addr(in_addr), .in_rdata(in_rdata),
      .adc_code(adc_code), .dig_in(dig_in), .dac_code(dac_code),
      .nv_wr(nv_wr), .nv_idx(nv_idx), .nv_data(nv_data));
   terminal_model u_term (.clk(clk), .adc_code(adc_code), .dig_in(dig_in),
      .nv_wr(nv_wr), .nv_idx(nv_idx), .nv_data(nv_data));
   // ==========================================================
   // Access tasks
   task automatic end_sim;
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      out_wr <= 1'b1;
      out_addr <= a;
      out_wdata <= d;
      @(posedge clk);
      out_wr <= 1'b0;
   endtask
   task automatic wr16(input logic [5:0] a, input logic [15:0] w);
      wr(a, w[7:0]);
      wr(a + 6'h01, w[15:8]);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      in_addr <= a;
      repeat (2) @(posedge clk);
      #1 d = in_rdata;
   endtask
   task automatic rd_byte(input string what, input logic [5:0] a,
                          input logic [7:0] exp);
      rd(a, b);
      chk(what, {8'h00, exp}, {8'h00, b});
   endtask
   task automatic rd_word(input string what, input logic [5:0] a,
                          input logic [15:0] exp);
      rd(a, b);
      rd(a + 6'h01, h);
      chk(what, exp, {h, b});
   endtask
   task automatic out_byte(input string what, input logic [5:0] a,
                           input logic [7:0] exp);
      @(posedge clk);
      out_addr <= a;
      repeat (2) @(posedge clk);
      #1 chk(what, {8'h00, exp}, {8'h00, out_rdata});
   endtask
   task automatic wait_status(input logic [5:0] a, input logic [7:0] exp);
      b = ~exp;
      for (int i = 0; i < 30 && b !== exp; i++) begin
         rd(a, b);
      end
      chk("status", {8'h00, exp}, {8'h00, b});
   endtask
   // ==========================================================
   // Tests
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd_byte("status idle", 6'h00, 8'h00);
      out_byte("ctrl idle", 6'h04, 8'h00);
      u_term.set_code(0, 12'hABC);
      u_term.set_code(1, 12'h123);
      u_term.set_code(8, 12'hFFF);
      u_term.set_dig(16'hA55A);
      repeat (4) @(posedge clk);
      rd_word("ch0 bipolar", 6'h02, 16'hABC0);
      rd_word("ch8 unipolar", 6'h22, 16'h7FF8);
      rd_word("digital", 6'h28, 16'hA55A);
      rd_byte("in pad", 6'h01, 8'h00);
      rd_byte("unmapped", 6'h2A, 8'h00);
      out_byte("out pad", 6'h05, 8'h00);
      out_byte("out digital", 6'h28, 8'h00);
      wr16(6'h12, 16'h4568);
      repeat (2) @(posedge clk);
      #1 chk("dac ch4", 16'h08AD, {4'h0, dac_code[4]});
      rd_word("ch4 in word", 6'h12, 16'h4568);
      wr16(6'h06, 16'h1234);
      wr(6'h04, 8'hC5);
      wait_status(6'h04, 8'hC5);
      repeat (2) @(posedge clk);
      chk("retained 5", 16'h1234, u_term.store[10'h045]);
      wr16(6'h06, 16'hBEEF);
      wr(6'h04, 8'hC6);
      wait_status(6'h04, 8'hC6);
      repeat (2) @(posedge clk);
      chk("retained 6", 16'hBEEF, u_term.store[10'h046]);
      wr(6'h04, 8'h85);
      wait_status(6'h04, 8'h85);
      rd_word("reg read", 6'h06, 16'h1234);
      wr(6'h04, 8'h05);
      wait_status(6'h04, 8'h00);
      @(posedge clk);
      cfg_complete <= 1'b0;
      repeat (3) @(posedge clk);
      rd_word("std ch8", 6'h08, 16'h7FF8);
      rd_word("std digital", 6'h0C, 16'hA55A);
      wr16(6'h02, 16'h0FF8);
      repeat (2) @(posedge clk);
      #1 chk("dac ch5", 16'h01FF, {4'h0, dac_code[5]});
      @(posedge clk);
      cfg_extended <= 10'h002;
      repeat (3) @(posedge clk);
      rd_word("ext ch1", 6'h04, 16'h1230);
      rd_word("ext ch8", 6'h0A, 16'h7FF8);
      rd_word("ext digital", 6'h0E, 16'hA55A);
      end_sim;
   end
   initial begin
      #400000;
      n_fail++;
      end_sim;
   end
endmodule

/* File: terminal_model.sv */
// Terminal side model: converter codes, digital inputs, retained store.
// Assumes register write notices are one-cycle pulses on clk.
`timescale 1ns/10ps
module terminal_model (
   // Clock
   input wire logic clk,
   // Terminal side
   output logic [analog_pi_pkg::CH_NUM-1:0][analog_pi_pkg::ADC_W-1:0] adc_code,
   output logic [analog_pi_pkg::DIG_W-1:0] dig_in,
   // Retained store notices
   input wire logic nv_wr,
   input wire logic [analog_pi_pkg::REG_IDX_W-1:0] nv_idx,
   input wire logic [analog_pi_pkg::WORD_W-1:0] nv_data
);
   logic [analog_pi_pkg::WORD_W-1:0] store [analog_pi_pkg::REG_DEPTH];
   initial begin
      adc_code = '0;
      dig_in = 16'h0000;
   end
   // Sets one converter code at the next edge.
   task automatic set_code(input int ch, input logic [11:0] code);
      @(posedge clk);
      adc_code[ch] <= code;
   endtask
   task automatic set_dig(input logic [15:0] v);
      @(posedge clk);
      dig_in <= v;
   endtask
   always @(posedge clk) begin
      if (nv_wr === 1'b1) begin
         store[nv_idx] <= nv_data;
      end
   end
endmodule

/* File: terminal_register_file.sv */
// Register sets of all channels, 64 words each, in one array.
// Assumes the array sits in retained storage; it has no reset.

`timescale 1ns/10ps

module terminal_register_file (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Write port
   input wire logic wr_en,
   input wire logic [analog_pi_pkg::REG_IDX_W-1:0] wr_idx,
   input wire logic [analog_pi_pkg::WORD_W-1:0] wr_data,
   // Read port
   input wire logic [analog_pi_pkg::REG_IDX_W-1:0] rd_idx,
   output logic [analog_pi_pkg::WORD_W-1:0] rd_data
);

   // ==========================================================
   // Storage
   logic [analog_pi_pkg::WORD_W-1:0] mem [analog_pi_pkg::REG_DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // ==========================================================
   // Read
   logic [analog_pi_pkg::WORD_W-1:0] rd_data_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_ff <= '0;
      end else begin
         rd_data_ff <= mem[rd_idx];
      end
   end

   assign rd_data = rd_data_ff;

endmodule
